/* design/synth_ctrl_pkg.sv */
`default_nettype none
package synth_ctrl_pkg;

  // serial frame and word addressing
  localparam int FRAME_W = 18;
  localparam logic ADDR_FEEDBACK = 1'b0;
  localparam logic ADDR_REFERENCE = 1'b1;
  localparam logic [17:0] FEEDBACK_RESET = 18'h00000;
  localparam logic [17:0] REFERENCE_RESET = 18'h00001;

  // sleep mode codes
  localparam logic [1:0] SLEEP_NORMAL = 2'h0;
  localparam logic [1:0] SLEEP_SYNC = 2'h1;
  localparam logic [1:0] SLEEP_CRESET = 2'h2;
  localparam logic [1:0] SLEEP_ASYNC = 2'h3;

  // status pin selections
  localparam logic [1:0] SEL_DIGITAL_LOCK = 2'h0;
  localparam logic [1:0] SEL_ANALOG_LOCK = 2'h1;
  localparam logic [1:0] SEL_REF_DIV = 2'h2;
  localparam logic [1:0] SEL_FB_DIV = 2'h3;

  // timing
  localparam int CORE_MHZ = 50;
  localparam int LOCK_WIN_NS = 15;
  localparam int LOCK_WIDE_NS = 30;
  localparam int WAKE_NS = 1500;
  localparam int LOCK_GOOD_NEEDED = 5;
  localparam int LOCK_WIN_CYC = (LOCK_WIN_NS * CORE_MHZ / 1000 < 1) ? 1 :
                                LOCK_WIN_NS * CORE_MHZ / 1000;
  localparam int LOCK_WIDE_CYC = (LOCK_WIDE_NS * CORE_MHZ / 1000 < 1) ? 1 :
                                 LOCK_WIDE_NS * CORE_MHZ / 1000;
  localparam int WAKE_CYC = (WAKE_NS * CORE_MHZ + 999) / 1000;

  // field layouts, bit 17 first
  typedef struct packed {
    logic [2:0] ref_buffer_tune;
    logic [1:0] status_pin_select;
    logic detector_polarity;
    logic pump_hiz;
    logic [9:0] ref_divide_value;
    logic addr;
  } ref_word_s;

  typedef struct packed {
    logic [9:0] binary_count;
    logic [4:0] swallow_count;
    logic [1:0] sleep_mode_sel;
    logic addr;
  } fb_word_s;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_SYNC_WAIT = 5'h02,
    ST_DOWN = 5'h04,
    ST_CRESET = 5'h08,
    ST_WAKE = 5'h10
  } mode_e;

endpackage : synth_ctrl_pkg
`default_nettype wire

/* design/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins in, synchronised out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= pin;
      q <= stage1;
    end
  end
endmodule : pin_sync
`default_nettype wire

/* design/load_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module load_divider #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic hold,
  input wire logic step,
  input wire logic [W-1:0] load_value,
  // terminal count pulse
  output logic tick
);
  logic [W-1:0] count;

  // hold parks the counter at its load point
  always_ff @(posedge clk) begin
    if (rst || hold) begin
      count <= load_value;
      tick <= 1'b0;
    end else if (step) begin
      if (count <= W'(1)) begin
        count <= load_value;
        tick <= 1'b1;
      end else begin
        count <= count - W'(1);
        tick <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule : load_divider
`default_nettype wire

/* design/synth_serial_ctrl_lockdet.sv */
// Contract
// - data pin shifts into 18-bit register on rising serial clock, MSB first.
// - load strobe rise copies frame to reference word if bit 0 set, else feedback.
// - reference word: tune 17:15, pin select 14:13, polarity 12, hiz 11, divide 10:1.
// - feedback word: binary 17:8, swallow 7:3, sleep mode 2:1.
// - status pin shows digital lock (0), analog lock (1) or divider outputs.
// - select 2 shows reference divider, 3 feedback divider, push-pull.
// - any power-down floats the status pin whatever the select.
// - analog lock is open-drain, low while pump active, floating otherwise.
// - lock asserts after five consecutive comparisons inside the 15 ns window.
// - once locked, window widens to 30 ns; larger error drops lock.
// - mode follows enable pin and sleep code; enable low is asynchronous power-down.
// - power-down disables buffer, prescaler, detector, pump; dividers held loaded.
// - leaving power-down, dividers stay loaded 1.5 us then start aligned.
// - shifting and latching keep working in every power-down mode.
// - synchronous power-down waits for next pump pulse to complete.
// - asynchronous power-down takes effect at once.
// - counter reset holds dividers loaded; normal restarts them with no delay.
// - pump hiz bit floats the pump output; clear lets pump run.
// - polarity 0 suits negative tuning, 1 positive tuning.
`timescale 1ns/1ps
`default_nettype none
module synth_serial_ctrl_lockdet
  import synth_ctrl_pkg::*;
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  // device pins
  input wire logic chip_enable,
  input wire logic ref_in,
  input wire logic prescaler_in,
  // charge pump output pin
  output logic pump_output_pin_o,
  output logic pump_output_pin_oe,
  // multi-function status pin
  output logic status_out_pin_o,
  output logic status_out_pin_oe,
  // analog section enables and reference buffer tune
  output logic osc_buffer_en,
  output logic prescaler_en,
  output logic detector_en,
  output logic [2:0] ref_buffer_tune
);

  logic [FRAME_W-1:0] shift_q;
  logic le_s, ce_s, ref_s, pre_s;
  logic le_prev, ref_prev, pre_prev;
  logic le_rise, ref_step, pre_step;
  ref_word_s ref_word;
  fb_word_s fb_word;
  mode_e state, next_state;
  logic [7:0] wake_cnt;
  logic async_req, powered, div_hold, pfd_run;
  logic ref_tick, fb_tick;
  logic up, dn, next_up, next_dn, cmp_evt, next_cmp;
  logic [7:0] err_cnt, err_meas;
  logic [2:0] good_cnt;
  logic locked;
  logic [14:0] fb_load;

  // link side: the shift register lives on the serial clock
  always_ff @(posedge serial_clk) begin
    shift_q <= {shift_q[FRAME_W-2:0], serial_data};
  end

  pin_sync #(.W(4)) u_sync (
    .clk(core_clk),
    .rst(rst),
    .pin({load_strobe, chip_enable, ref_in, prescaler_in}),
    .q({le_s, ce_s, ref_s, pre_s})
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      le_prev <= 1'b0;
      ref_prev <= 1'b0;
      pre_prev <= 1'b0;
    end else begin
      le_prev <= le_s;
      ref_prev <= ref_s;
      pre_prev <= pre_s;
    end
  end

  assign le_rise = le_s && !le_prev;
  assign ref_step = ref_s && !ref_prev;
  assign pre_step = pre_s && !pre_prev;

  // the host keeps the serial clock still while the strobe rises, so
  // the shift register is static when the synchronised edge reads it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_word <= ref_word_s'(REFERENCE_RESET);
      fb_word <= fb_word_s'(FEEDBACK_RESET);
    end else if (le_rise) begin
      if (shift_q[0] == ADDR_REFERENCE) begin
        ref_word <= ref_word_s'(shift_q);
      end else begin
        fb_word <= fb_word_s'(shift_q);
      end
    end
  end

  // power mode sequencing
  assign async_req = !ce_s || (fb_word.sleep_mode_sel == SLEEP_ASYNC);

  always_comb begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        if (async_req) begin
          next_state = ST_DOWN;
        end else if (fb_word.sleep_mode_sel == SLEEP_SYNC) begin
          next_state = ST_SYNC_WAIT;
        end else if (fb_word.sleep_mode_sel == SLEEP_CRESET) begin
          next_state = ST_CRESET;
        end
      end
      ST_SYNC_WAIT: begin
        if (async_req) begin
          next_state = ST_DOWN;
        end else if (fb_word.sleep_mode_sel == SLEEP_SYNC) begin
          if (cmp_evt) begin
            next_state = ST_DOWN;
          end
        end else if (fb_word.sleep_mode_sel == SLEEP_CRESET) begin
          next_state = ST_CRESET;
        end else begin
          next_state = ST_NORMAL;
        end
      end
      ST_DOWN: begin
        if (!async_req) begin
          if (fb_word.sleep_mode_sel == SLEEP_NORMAL) begin
            next_state = ST_WAKE;
          end else if (fb_word.sleep_mode_sel == SLEEP_CRESET) begin
            next_state = ST_CRESET;
          end
        end
      end
      ST_CRESET: begin
        if (async_req) begin
          next_state = ST_DOWN;
        end else if (fb_word.sleep_mode_sel == SLEEP_SYNC) begin
          next_state = ST_SYNC_WAIT;
        end else if (fb_word.sleep_mode_sel == SLEEP_NORMAL) begin
          next_state = ST_NORMAL;
        end
      end
      ST_WAKE: begin
        if (async_req || fb_word.sleep_mode_sel == SLEEP_SYNC) begin
          next_state = ST_DOWN;
        end else if (fb_word.sleep_mode_sel == SLEEP_CRESET) begin
          next_state = ST_CRESET;
        end else if (wake_cnt == 8'h00) begin
          next_state = ST_NORMAL;
        end
      end
      default: next_state = ST_DOWN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_DOWN;
    end else begin
      state <= next_state;
    end
  end

  // wake hold counter: runs only while waking
  always_ff @(posedge core_clk) begin
    if (rst || state != ST_WAKE) begin
      wake_cnt <= 8'(WAKE_CYC - 1);
    end else if (wake_cnt != 8'h00) begin
      wake_cnt <= wake_cnt - 8'h01;
    end
  end

  assign powered = (state != ST_DOWN);
  assign div_hold = (state == ST_DOWN) || (state == ST_CRESET) ||
                    (state == ST_WAKE);
  assign pfd_run = powered && !div_hold;
  assign fb_load = {fb_word.binary_count, 5'h00} +
                   {10'h000, fb_word.swallow_count};

  // both dividers release on the same edge, so they start aligned
  load_divider #(.W(10)) u_ref_div (
    .clk(core_clk),
    .rst(rst),
    .hold(div_hold),
    .step(ref_step),
    .load_value(ref_word.ref_divide_value),
    .tick(ref_tick)
  );

  load_divider #(.W(15)) u_fb_div (
    .clk(core_clk),
    .rst(rst),
    .hold(div_hold),
    .step(pre_step),
    .load_value(fb_load),
    .tick(fb_tick)
  );

  // phase/frequency detector: first arrival opens, second closes
  always_comb begin
    next_up = up || ref_tick;
    next_dn = dn || fb_tick;
    next_cmp = 1'b0;
    if (!pfd_run) begin
      next_up = 1'b0;
      next_dn = 1'b0;
    end else if (next_up && next_dn) begin
      next_up = 1'b0;
      next_dn = 1'b0;
      next_cmp = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      up <= 1'b0;
      dn <= 1'b0;
      cmp_evt <= 1'b0;
    end else begin
      up <= next_up;
      dn <= next_dn;
      cmp_evt <= next_cmp;
    end
  end

  // phase error in core cycles, frozen at each comparison
  always_ff @(posedge core_clk) begin
    if (rst || next_cmp || !pfd_run) begin
      err_cnt <= 8'h00;
    end else if ((up || dn) && err_cnt != 8'hff) begin
      err_cnt <= err_cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_meas <= 8'h00;
    end else if (next_cmp) begin
      err_meas <= err_cnt;
    end
  end

  // digital lock filter
  always_ff @(posedge core_clk) begin
    if (rst || !pfd_run) begin
      good_cnt <= 3'h0;
      locked <= 1'b0;
    end else if (cmp_evt) begin
      if (locked) begin
        if (err_meas > 8'(LOCK_WIDE_CYC)) begin
          locked <= 1'b0;
          good_cnt <= 3'h0;
        end
      end else if (err_meas < 8'(LOCK_WIN_CYC)) begin
        if (good_cnt == 3'(LOCK_GOOD_NEEDED - 1)) begin
          locked <= 1'b1;
        end else begin
          good_cnt <= good_cnt + 3'h1;
        end
      end else begin
        good_cnt <= 3'h0;
      end
    end
  end

  // charge pump pin: high sources, low sinks
  always_ff @(posedge core_clk) begin
    if (rst || !powered || ref_word.pump_hiz) begin
      pump_output_pin_oe <= 1'b0;
      pump_output_pin_o <= 1'b0;
    end else begin
      pump_output_pin_oe <= up || dn;
      pump_output_pin_o <= ref_word.detector_polarity ? up : dn;
    end
  end

  // multi-function status pin
  always_ff @(posedge core_clk) begin
    if (rst || !powered) begin
      status_out_pin_oe <= 1'b0;
      status_out_pin_o <= 1'b0;
    end else begin
      case (ref_word.status_pin_select)
        SEL_DIGITAL_LOCK: begin
          status_out_pin_oe <= 1'b1;
          status_out_pin_o <= locked;
        end
        SEL_ANALOG_LOCK: begin
          status_out_pin_oe <= up || dn;
          status_out_pin_o <= 1'b0;
        end
        SEL_REF_DIV: begin
          status_out_pin_oe <= 1'b1;
          status_out_pin_o <= ref_tick;
        end
        default: begin
          status_out_pin_oe <= 1'b1;
          status_out_pin_o <= fb_tick;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_buffer_en <= 1'b0;
      prescaler_en <= 1'b0;
      detector_en <= 1'b0;
      ref_buffer_tune <= 3'h0;
    end else begin
      osc_buffer_en <= powered;
      prescaler_en <= powered;
      detector_en <= powered;
      ref_buffer_tune <= ref_word.ref_buffer_tune;
    end
  end

  // checks: two clock domains, so every property names its own clock

  sequence pulse_open;
    (up || dn) && !cmp_evt;
  endsequence

  sequence wake_start;
    state == ST_DOWN ##1 state == ST_WAKE;
  endsequence

  chk_shift_msb: assert property (
    @(posedge serial_clk) disable iff (rst)
    1'b1 ##18 1'b1 |-> shift_q[17] == $past(serial_data, 18))
    else $error("serial bit not at top after 18 clocks");

  chk_frame_route: assert property (
    @(posedge core_clk) disable iff (rst)
    le_rise |=> (($past(shift_q[0]) == ADDR_REFERENCE) ?
      ref_word == ref_word_s'($past(shift_q)) :
      fb_word == fb_word_s'($past(shift_q))))
    else $error("frame not latched into addressed word");

  chk_status_float: assert property (
    @(posedge core_clk) disable iff (rst)
    state == ST_DOWN |=> !status_out_pin_oe)
    else $error("status pin driven in power-down");

  chk_analog_od: assert property (
    @(posedge core_clk) disable iff (rst)
    status_out_pin_oe && $past(ref_word.status_pin_select) == SEL_ANALOG_LOCK
    |-> !status_out_pin_o && $past(up || dn))
    else $error("analog lock output not open-drain low");

  chk_lock_five: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(locked) |-> $past(good_cnt) == 3'(LOCK_GOOD_NEEDED - 1) &&
      $past(err_meas) < 8'(LOCK_WIN_CYC))
    else $error("lock asserted without five good comparisons");

  chk_async_now: assert property (
    @(posedge core_clk) disable iff (rst)
    async_req && state != ST_DOWN |=> state == ST_DOWN)
    else $error("asynchronous power-down delayed");

  chk_sync_waits: assert property (
    @(posedge core_clk) disable iff (rst)
    state == ST_SYNC_WAIT && !async_req && !cmp_evt &&
      fb_word.sleep_mode_sel == SLEEP_SYNC |=> state == ST_SYNC_WAIT)
    else $error("synchronous power-down entered before pulse end");

  chk_wake_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    wake_start |-> div_hold [*8])
    else $error("dividers released early after power-down");

  chk_wake_release: assert property (
    @(posedge core_clk) disable iff (rst)
    state == ST_WAKE && wake_cnt == 8'h00 && !async_req &&
      fb_word.sleep_mode_sel == SLEEP_NORMAL |=> !div_hold)
    else $error("dividers not released after wake delay");

  chk_creset_fast: assert property (
    @(posedge core_clk) disable iff (rst)
    state == ST_CRESET && !async_req &&
      fb_word.sleep_mode_sel == SLEEP_NORMAL |=> state == ST_NORMAL)
    else $error("counter reset exit delayed");

  chk_pump_hiz: assert property (
    @(posedge core_clk) disable iff (rst)
    ref_word.pump_hiz |=> !pump_output_pin_oe)
    else $error("pump driven while hiz set");

  chk_lock_drop: assert property (
    @(posedge core_clk) disable iff (rst)
    locked && cmp_evt && err_meas > 8'(LOCK_WIDE_CYC) |=> !locked)
    else $error("lock held beyond wide window");

  chk_pulse_pin: assert property (
    @(posedge core_clk) disable iff (rst)
    pulse_open and powered and !ref_word.pump_hiz |=> pump_output_pin_oe)
    else $error("pump pin idle during pulse");

endmodule : synth_serial_ctrl_lockdet
`default_nettype wire

/* testbench/serial_host.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  // serial link toward the device
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // 32 ns link clock, standing low between frames
  task automatic send(input logic [17:0] frame, input logic strobe);
    for (int i = 17; i >= 0; i--) begin
      serial_data = frame[i];
      #16 serial_clk = 1'b1;
      #16 serial_clk = 1'b0;
    end
    // released data line must not keep showing the last bit
    serial_data = ~frame[0];
    if (strobe) begin
      #16 load_strobe = 1'b1;
      #100 load_strobe = 1'b0;
    end
    #100;
  endtask : send
endmodule : serial_host
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import synth_ctrl_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic chip_enable = 1'b1;
  logic ref_in = 1'b0;
  logic prescaler_in = 1'b0;
  logic run = 1'b0;
  wire serial_clk;
  wire serial_data;
  wire load_strobe;
  wire pump_output_pin_o;
  wire pump_output_pin_oe;
  wire status_out_pin_o;
  wire status_out_pin_oe;
  wire osc_buffer_en;
  wire prescaler_en;
  wire detector_en;
  wire [2:0] ref_buffer_tune;
  wire [2:0] ens;
  int mismatches = 0;
  int comparisons = 0;
  int lag = 0;
  int ph = 0;
  int pulses;
  logic st_oe, od_bad, pu_oe, pu_src;

  assign ens = {osc_buffer_en, prescaler_en, detector_en};

  initial forever #10 core_clk = ~core_clk;

  // 8-cycle reference and prescaler waves, prescaler lagging by lag cycles
  always @(negedge core_clk) begin
    if (run) ph <= (ph + 1) % 8;
    ref_in <= run && ph < 4;
    prescaler_in <= run && ((ph + 8 - lag) % 8) < 4;
  end

  serial_host i_serial_host (
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .load_strobe(load_strobe)
  );

  synth_serial_ctrl_lockdet i_synth_serial_ctrl_lockdet (
    .core_clk(core_clk),
    .rst(rst),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .load_strobe(load_strobe),
    .chip_enable(chip_enable),
    .ref_in(ref_in),
    .prescaler_in(prescaler_in),
    .pump_output_pin_o(pump_output_pin_o),
    .pump_output_pin_oe(pump_output_pin_oe),
    .status_out_pin_o(status_out_pin_o),
    .status_out_pin_oe(status_out_pin_oe),
    .osc_buffer_en(osc_buffer_en),
    .prescaler_en(prescaler_en),
    .detector_en(detector_en),
    .ref_buffer_tune(ref_buffer_tune)
  );

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic wr_ref(input logic [2:0] tune, input logic [1:0] sel,
                        input logic pol, input logic hiz,
                        input logic [9:0] div);
    i_serial_host.send({tune, sel, pol, hiz, div, ADDR_REFERENCE}, 1'b1);
    repeat (6) @(negedge core_clk);
  endtask : wr_ref

  task automatic wr_fb(input logic [9:0] bin, input logic [4:0] swal,
                       input logic [1:0] sleep);
    i_serial_host.send({bin, swal, sleep, ADDR_FEEDBACK}, 1'b1);
    repeat (6) @(negedge core_clk);
  endtask : wr_fb

  // gathers pin activity over n cycles
  task automatic observe(input int n);
    pulses = 0;
    st_oe = 1'b0;
    od_bad = 1'b0;
    pu_oe = 1'b0;
    pu_src = 1'b0;
    repeat (n) begin
      @(negedge core_clk);
      if (status_out_pin_oe === 1'b1) begin
        st_oe = 1'b1;
        if (status_out_pin_o !== 1'b0) od_bad = 1'b1;
        if (status_out_pin_o === 1'b1) pulses++;
      end
      if (pump_output_pin_oe === 1'b1) begin
        pu_oe = 1'b1;
        if (pump_output_pin_o === 1'b1) pu_src = 1'b1;
      end
    end
  endtask : observe

  initial begin
    repeat (10000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    repeat (100) @(negedge core_clk);
    check(18'(ens), 18'h7);
    check(18'({status_out_pin_oe, status_out_pin_o}), 18'h2);
    // surplus bits ahead of the real frame must fall out
    i_serial_host.send(18'h0aaaa, 1'b0);
    wr_ref(3'h7, SEL_REF_DIV, 1'b1, 1'b0, 10'h002);
    check(18'(ref_buffer_tune), 18'h7);
    wr_fb(10'h281, 5'h00, SLEEP_NORMAL);
    check(18'(ref_buffer_tune), 18'h7);
    wr_fb(10'h000, 5'h01, SLEEP_NORMAL);
    run = 1'b1;
    observe(160);
    check(18'(pulses > 8 && pulses < 12), 18'h1);
    wr_ref(3'h7, SEL_FB_DIV, 1'b1, 1'b0, 10'h002);
    observe(160);
    check(18'(pulses > 18 && pulses < 22), 18'h1);
    wr_ref(3'h7, SEL_DIGITAL_LOCK, 1'b1, 1'b0, 10'h001);
    lag = 3;
    repeat (40) @(negedge core_clk);
    check(18'(status_out_pin_o), 18'h0);
    lag = 0;
    repeat (16) @(negedge core_clk);
    check(18'(status_out_pin_o), 18'h0);
    repeat (64) @(negedge core_clk);
    check(18'({status_out_pin_oe, status_out_pin_o}), 18'h3);
    lag = 2;
    repeat (48) @(negedge core_clk);
    check(18'(status_out_pin_o), 18'h1);
    lag = 3;
    repeat (48) @(negedge core_clk);
    check(18'(status_out_pin_o), 18'h0);
    wr_ref(3'h7, SEL_ANALOG_LOCK, 1'b1, 1'b0, 10'h001);
    observe(80);
    check(18'({st_oe, od_bad}), 18'h2);
    check(18'({pu_oe, pu_src}), 18'h3);
    wr_ref(3'h7, SEL_ANALOG_LOCK, 1'b0, 1'b0, 10'h001);
    observe(80);
    check(18'({pu_oe, pu_src}), 18'h2);
    wr_ref(3'h7, SEL_ANALOG_LOCK, 1'b0, 1'b1, 10'h001);
    observe(80);
    check(18'(pu_oe), 18'h0);
    wr_ref(3'h7, SEL_REF_DIV, 1'b1, 1'b0, 10'h002);
    wr_fb(10'h000, 5'h01, SLEEP_CRESET);
    observe(80);
    check(18'({ens, st_oe, pulses == 0}), 18'h1f);
    wr_fb(10'h000, 5'h01, SLEEP_NORMAL);
    observe(40);
    check(18'(pulses > 0), 18'h1);
    chip_enable = 1'b0;
    repeat (6) @(negedge core_clk);
    check(18'({ens, status_out_pin_oe, pump_output_pin_oe}), 18'h0);
    wr_ref(3'h5, SEL_REF_DIV, 1'b1, 1'b0, 10'h002);
    check(18'(ref_buffer_tune), 18'h5);
    chip_enable = 1'b1;
    observe(60);
    check(18'(pulses), 18'h0);
    observe(60);
    check(18'(pulses > 0), 18'h1);
    // no divider edges means no pump event to wait for
    run = 1'b0;
    repeat (20) @(negedge core_clk);
    wr_fb(10'h000, 5'h01, SLEEP_SYNC);
    repeat (60) @(negedge core_clk);
    check(18'(ens), 18'h7);
    run = 1'b1;
    repeat (60) @(negedge core_clk);
    check(18'(ens), 18'h0);
    wr_fb(10'h000, 5'h01, SLEEP_NORMAL);
    repeat (100) @(negedge core_clk);
    check(18'(ens), 18'h7);
    wr_fb(10'h000, 5'h01, SLEEP_ASYNC);
    repeat (6) @(negedge core_clk);
    check(18'(ens), 18'h0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
